// ### hw/fsr_defines.vh
`ifndef FSR_DEFINES_VH
`define FSR_DEFINES_VH

// command codes
`define FSR_CMD_RESET_EN    8'h66
`define FSR_CMD_RESET       8'h99
`define FSR_CMD_WREN        8'h06
`define FSR_CMD_WREN_VOL    8'h50
`define FSR_CMD_WRDIS       8'h04
`define FSR_CMD_WR_STATUS   8'h01
`define FSR_CMD_WR_STATUS3  8'h11
`define FSR_CMD_RD_STATUS1  8'h05
`define FSR_CMD_RD_STATUS2  8'h35
`define FSR_CMD_RD_STATUS3  8'h15
`define FSR_CMD_QPI_ENTER   8'h38
`define FSR_CMD_QPI_EXIT    8'hFF

// status_one field positions
`define FSR_S1_SREG_PROTECT_LO  7
`define FSR_S1_GRANULARITY      6
`define FSR_S1_DIRECTION        5
`define FSR_S1_BLOCK_PROTECT_HI 4
`define FSR_S1_BLOCK_PROTECT_LO 2
`define FSR_S1_WEL              1
`define FSR_S1_BUSY             0

// status_two field positions
`define FSR_S2_ERASE_SUSP       7
`define FSR_S2_PROTECT_INVERT   6
`define FSR_S2_LOCK_HI          5
`define FSR_S2_LOCK_LO          3
`define FSR_S2_PROG_SUSP        2
`define FSR_S2_QUAD_ENABLE      1
`define FSR_S2_SREG_PROTECT_HI  0

// status_three field position
`define FSR_S3_PIN_FUNCTION     7

// factory values of the non-volatile bits
`define FSR_NV_S1_HI_RESET      6'h00
`define FSR_NV_BIT_RESET        1'b0
`define FSR_NV_LOCK_RESET       3'h0

// timing
`define FSR_CLK_MHZ             50
`define FSR_CLK_NS              20
`define FSR_T_RST_US            30
`define FSR_T_RST_CYC           ((`FSR_T_RST_US * 1000 + `FSR_CLK_NS - 1) / `FSR_CLK_NS)
`define FSR_T_RESET_NS          1000
`define FSR_T_RESET_CYC         ((`FSR_T_RESET_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS)
`define FSR_T_W_US              5000

`endif

// ### hw/fsr_sync.v
`timescale 1ns/1ps
module fsr_sync #(
	parameter             WIDTH     = 1,
	parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
	// clock and reset
	input  wire             clk,
	input  wire             reset_n,
	input  wire             clk_en,
	// pins
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] stage1;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stage1   <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else if (clk_en) begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule

// ### hw/fsr_shifter.v
`timescale 1ns/1ps
module fsr_shifter (
	// clock and reset
	input  wire       clk,
	input  wire       reset_n,
	input  wire       clk_en,
	// serial side
	input  wire       sel,
	input  wire       rise,
	input  wire       quad,
	input  wire [3:0] din,
	// byte side
	output reg  [7:0] byte_out,
	output reg        byte_valid
);

	reg  [7:0] shreg;
	reg  [2:0] cnt;
	wire [7:0] next_shreg = quad ? {shreg[3:0], din} : {shreg[6:0], din[0]};
	wire       done       = quad ? cnt[2] : (cnt == 3'h7);

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shreg      <= 8'h00;
			cnt        <= 3'h0;
			byte_out   <= 8'h00;
			byte_valid <= 1'b0;
		end else if (clk_en) begin
			byte_valid <= 1'b0;
			if (!sel) begin
				cnt <= 3'h0;
			end else if (rise) begin
				shreg <= next_shreg;
				cnt   <= quad ? cnt + 3'h4 : cnt + 3'h1;
				if (done) begin
					byte_out   <= next_shreg;
					byte_valid <= 1'b1;
				end
			end
		end
	end

endmodule

// ### hw/fsr_status_ctrl.v
// Behaviour
// - reset-enable then reset, back to back, resets device in single or quad mode.
// - after a software reset all commands are ignored until recovery time ends.
// - pin-function bit clear makes shared pin hold; set makes it active-low reset.
// - hardware reset aborts program or erase in progress.
// - while reset pin is low no command is accepted.
// - quad enable set disables hold and reset functions of the shared pin.
// - qualified hardware reset overrides all other inputs and aborts every operation.
// - protection, lock and quad-enable bits are kept non-volatile.
// - suspend, write-enable and busy bits are volatile, read-only, hardware updated.
// - write-enable latch set only by either write-enable; cleared when operation ends.
// - non-volatile status write needs protect permission, write enable, and in protect mode 01 wp unless quad.
// - power-up and software reset load volatile copies from non-volatile bits.
// - volatile write-enable before write-status updates volatile copies only.
// - granularity bit selects 64-KB blocks when clear, 4-KB sectors when set.
// - direction bit clear protects from top, set from bottom.
// - block-protect field all zeros leaves the array unprotected.
// - status_one bit 1 shows write enable, bit 0 shows busy.
// - status_two bit 7 erase suspended, bit 2 program suspended.
// - protect-invert bit set complements the protection map.
// - lock bits 5 to 3 are one-time set and guard security registers 3 to 1.
// - quad enable makes pins data lines, disabling write-protect and hold/reset.
// - status_one bit 7 and status_two bit 0 form the protect mode selector.
// - pin-function select is status_three bit 7, reset to zero.
// - protect mode zero ignores write-protect; writes allowed whenever write enabled.
`timescale 1ns/1ps
`include "fsr_defines.vh"
module fsr_status_ctrl #(
	parameter T_W_US = `FSR_T_W_US
) (
	// clock and reset
	input  wire       clk,
	input  wire       reset_n,
	input  wire       clk_en,
	// serial pins
	input  wire       cs_n,
	input  wire       sclk,
	input  wire [3:0] io_in,
	output reg  [3:0] io_out,
	output reg  [3:0] io_oe,
	// memory control side
	input  wire       array_busy,
	input  wire       array_done,
	input  wire       erase_suspended,
	input  wire       program_suspended,
	output reg        array_abort,
	output reg        in_reset,
	// status view
	output reg  [7:0] status_one,
	output reg  [7:0] status_two,
	output reg        pin_function_select,
	output reg        quad_instruction_mode
);

	localparam [31:0] TW_CYC    = (T_W_US * 1000 + `FSR_CLK_NS - 1) / `FSR_CLK_NS;
	localparam [31:0] REC_W     = `FSR_T_RST_CYC;
	localparam [31:0] RESET_W   = `FSR_T_RESET_CYC;
	localparam [15:0] REC_CYC   = REC_W[15:0];
	localparam [7:0]  RESET_CYC = RESET_W[7:0];
	localparam [1:0] ST_OPCODE = 2'h0;
	localparam [1:0] ST_DATA   = 2'h1;
	localparam [1:0] ST_READ   = 2'h2;

	// 00 free, 01 wp governed, 1x locked until power cycle or permanently
	function wr_allowed;
		input [1:0] mode;
		input       wp_high;
		input       quad_on;
		begin
			case (mode)
				2'h0:    wr_allowed = 1'b1;
				2'h1:    wr_allowed = wp_high | quad_on;
				default: wr_allowed = 1'b0;
			endcase
		end
	endfunction

	function is_read;
		input [7:0] op;
		begin
			is_read = (op == `FSR_CMD_RD_STATUS1) || (op == `FSR_CMD_RD_STATUS2) ||
				(op == `FSR_CMD_RD_STATUS3);
		end
	endfunction

	// pin synchronisers
	wire [5:0] pins_s;
	fsr_sync #(
		.WIDTH     (6),
		.RESET_VAL (6'h28)
	) u_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.clk_en   (clk_en),
		.async_in ({cs_n, sclk, io_in}),
		.sync_out (pins_s)
	);
	wire       s_cs_n = pins_s[5];
	wire       s_sclk = pins_s[4];
	wire [3:0] s_io   = pins_s[3:0];

	// non-volatile image and volatile copies
	reg [5:0] nv_s1_hi;
	reg       nv_protect_invert;
	reg       nv_quad_enable;
	reg       nv_sreg_protect_hi;
	reg [2:0] nv_lock;
	reg [5:0] vol_s1_hi;
	reg       vol_protect_invert;
	reg       vol_quad_enable;
	reg       write_enable_latch;
	reg       vol_wren;
	reg       reset_pending;

	// pending non-volatile write
	reg        nv_busy;
	reg [31:0] tw_cnt;
	reg [7:0]  new_s1;
	reg [7:0]  new_s2;
	reg        new_s2_valid;
	reg        new_pfs;
	reg        new_is_s3;

	// frame state
	reg [1:0]  state;
	reg [7:0]  opcode;
	reg [1:0]  data_cnt;
	reg        frame_dead;
	reg        cs_n_d;
	reg        sclk_d;
	reg [7:0]  out_sh;
	reg [2:0]  out_cnt;

	// reset machinery
	reg [7:0]  rst_low_cnt;
	reg [15:0] rec_cnt;
	wire busy = nv_busy | array_busy;
	wire [7:0] cur_s1 = {vol_s1_hi, write_enable_latch, busy};
	wire [7:0] cur_s2 = {erase_suspended, vol_protect_invert, nv_lock,
		program_suspended, vol_quad_enable, nv_sreg_protect_hi};
	wire [7:0] cur_s3 = {pin_function_select, 7'h00};

	// quad enable removes both pin roles
	wire pin_roles_on = ~vol_quad_enable;
	wire rst_pin_low  = pin_function_select & pin_roles_on & ~s_io[3];
	wire hold_now     = ~pin_function_select & pin_roles_on & ~s_io[3] & ~s_cs_n;
	wire hw_fire      = rst_pin_low && (rst_low_cnt == RESET_CYC - 8'h01);
	wire recovering   = (rec_cnt != 16'h0000);
	wire blocked      = rst_pin_low | recovering;
	wire accept       = ~s_cs_n & ~frame_dead & ~blocked;
	wire rise         = accept & ~hold_now & s_sclk & ~sclk_d;
	wire fall         = accept & ~hold_now & ~s_sclk & sclk_d;
	wire deselect     = s_cs_n & ~cs_n_d;
	wire [1:0] sp_mode = {nv_sreg_protect_hi, vol_s1_hi[5]};
	wire wr_ok = wr_allowed(sp_mode, s_io[2], vol_quad_enable);

	wire [7:0] rx_byte;
	wire       rx_valid;
	fsr_shifter u_shift (
		.clk        (clk),
		.reset_n    (reset_n),
		.clk_en     (clk_en),
		.sel        (accept),
		.rise       (rise),
		.quad       (quad_instruction_mode),
		.din        (s_io),
		.byte_out   (rx_byte),
		.byte_valid (rx_valid)
	);

	// a frame executes when chip select rises after a whole opcode
	wire exec    = deselect & ~frame_dead & ~blocked & (state != ST_OPCODE) & ~busy;
	wire sw_rst  = exec & (opcode == `FSR_CMD_RESET) & reset_pending;
	wire dev_rst = sw_rst | hw_fire;
	wire do_wsr  = exec & write_enable_latch & wr_ok & (data_cnt != 2'h0) &
		((opcode == `FSR_CMD_WR_STATUS) || (opcode == `FSR_CMD_WR_STATUS3));
	wire tw_end  = nv_busy && (tw_cnt == 32'h00000001);
	wire [7:0] rd_val = (opcode == `FSR_CMD_RD_STATUS1) ? cur_s1 :
		(opcode == `FSR_CMD_RD_STATUS2) ? cur_s2 : cur_s3;
	wire [7:0] rd_data = (out_cnt == 3'h0) ? rd_val : out_sh;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cs_n_d      <= 1'b1;
			sclk_d      <= 1'b0;
			rst_low_cnt <= 8'h00;
			rec_cnt     <= 16'h0000;
			frame_dead  <= 1'b0;
			in_reset    <= 1'b0;
			array_abort <= 1'b0;
		end else if (clk_en) begin
			cs_n_d      <= s_cs_n;
			sclk_d      <= s_sclk;
			array_abort <= dev_rst;
			in_reset    <= blocked | dev_rst;
			if (!rst_pin_low)
				rst_low_cnt <= 8'h00;
			else if (rst_low_cnt != RESET_CYC)
				rst_low_cnt <= rst_low_cnt + 8'h01;
			if (dev_rst)
				rec_cnt <= REC_CYC;
			else if (recovering)
				rec_cnt <= rec_cnt - 16'h0001;
			// a frame cut by reset stays dead until the host deselects
			if (s_cs_n)
				frame_dead <= 1'b0;
			else if (blocked | dev_rst)
				frame_dead <= 1'b1;
		end
	end

	// command frame decoding
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state    <= ST_OPCODE;
			opcode   <= 8'h00;
			data_cnt <= 2'h0;
			new_s1   <= 8'h00;
			new_s2   <= 8'h00;
			new_s2_valid <= 1'b0;
			new_pfs  <= 1'b0;
		end else if (clk_en) begin
			if (s_cs_n || !accept) begin
				if (s_cs_n)
					state <= ST_OPCODE;
				data_cnt <= 2'h0;
			end else if (rx_valid) begin
				case (state)
					ST_OPCODE: begin
						opcode <= rx_byte;
						state  <= is_read(rx_byte) ? ST_READ : ST_DATA;
					end
					ST_DATA: begin
						if (data_cnt == 2'h0) begin
							new_s1       <= rx_byte;
							new_pfs      <= rx_byte[`FSR_S3_PIN_FUNCTION];
							new_s2_valid <= 1'b0;
						end else if (data_cnt == 2'h1) begin
							new_s2       <= rx_byte;
							new_s2_valid <= 1'b1;
						end
						if (data_cnt != 2'h3)
							data_cnt <= data_cnt + 2'h1;
					end
					default: ;
				endcase
			end
		end
	end

	// status bits, write cycle and mode flags
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			nv_s1_hi              <= `FSR_NV_S1_HI_RESET;
			nv_protect_invert     <= `FSR_NV_BIT_RESET;
			nv_quad_enable        <= `FSR_NV_BIT_RESET;
			nv_sreg_protect_hi    <= `FSR_NV_BIT_RESET;
			nv_lock               <= `FSR_NV_LOCK_RESET;
			pin_function_select   <= `FSR_NV_BIT_RESET;
			vol_s1_hi             <= `FSR_NV_S1_HI_RESET;
			vol_protect_invert    <= `FSR_NV_BIT_RESET;
			vol_quad_enable       <= `FSR_NV_BIT_RESET;
			write_enable_latch    <= 1'b0;
			vol_wren              <= 1'b0;
			reset_pending         <= 1'b0;
			quad_instruction_mode <= 1'b0;
			nv_busy               <= 1'b0;
			tw_cnt                <= 32'h00000000;
			new_is_s3             <= 1'b0;
		end else if (clk_en) begin
			if (dev_rst) begin
				// volatile copies reload, non-volatile image survives
				vol_s1_hi             <= nv_s1_hi;
				vol_protect_invert    <= nv_protect_invert;
				vol_quad_enable       <= nv_quad_enable;
				write_enable_latch    <= 1'b0;
				vol_wren              <= 1'b0;
				reset_pending         <= 1'b0;
				quad_instruction_mode <= 1'b0;
				nv_busy               <= 1'b0;
			end else begin
				if (array_done)
					write_enable_latch <= 1'b0;
				if (exec)
					reset_pending <= (opcode == `FSR_CMD_RESET_EN);
				if (exec && (opcode == `FSR_CMD_WRDIS))
					write_enable_latch <= 1'b0;
				if (exec && (opcode == `FSR_CMD_QPI_ENTER) && vol_quad_enable)
					quad_instruction_mode <= 1'b1;
				if (exec && (opcode == `FSR_CMD_QPI_EXIT))
					quad_instruction_mode <= 1'b0;
				if (do_wsr && vol_wren) begin
					// fast path: no cell wear, lost at next reset
					write_enable_latch <= 1'b0;
					if (opcode == `FSR_CMD_WR_STATUS) begin
						vol_s1_hi <= new_s1[`FSR_S1_SREG_PROTECT_LO:`FSR_S1_BLOCK_PROTECT_LO];
						if (new_s2_valid) begin
							vol_protect_invert <= new_s2[`FSR_S2_PROTECT_INVERT];
							vol_quad_enable    <= new_s2[`FSR_S2_QUAD_ENABLE];
						end
					end
				end else if (do_wsr) begin
					nv_busy   <= 1'b1;
					tw_cnt    <= TW_CYC;
					new_is_s3 <= (opcode == `FSR_CMD_WR_STATUS3);
				end
				if (nv_busy)
					tw_cnt <= tw_cnt - 32'h00000001;
				if (tw_end) begin
					nv_busy            <= 1'b0;
					write_enable_latch <= 1'b0;
					if (new_is_s3) begin
						pin_function_select <= new_pfs;
					end else begin
						nv_s1_hi  <= new_s1[`FSR_S1_SREG_PROTECT_LO:`FSR_S1_BLOCK_PROTECT_LO];
						vol_s1_hi <= new_s1[`FSR_S1_SREG_PROTECT_LO:`FSR_S1_BLOCK_PROTECT_LO];
						if (new_s2_valid) begin
							nv_protect_invert  <= new_s2[`FSR_S2_PROTECT_INVERT];
							vol_protect_invert <= new_s2[`FSR_S2_PROTECT_INVERT];
							nv_quad_enable     <= new_s2[`FSR_S2_QUAD_ENABLE];
							vol_quad_enable    <= new_s2[`FSR_S2_QUAD_ENABLE];
							nv_sreg_protect_hi <= new_s2[`FSR_S2_SREG_PROTECT_HI];
							// lock bits only ever set
							nv_lock <= nv_lock | new_s2[`FSR_S2_LOCK_HI:`FSR_S2_LOCK_LO];
						end
					end
				end
				// command set placed last so it wins over a same-cycle clear
				if (exec && (opcode == `FSR_CMD_WREN)) begin
					write_enable_latch <= 1'b1;
					vol_wren           <= 1'b0;
				end
				if (exec && (opcode == `FSR_CMD_WREN_VOL)) begin
					write_enable_latch <= 1'b1;
					vol_wren           <= 1'b1;
				end
			end
		end
	end

	// status readout and exported view
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			out_sh     <= 8'h00;
			out_cnt    <= 3'h0;
			io_out     <= 4'h0;
			io_oe      <= 4'h0;
			status_one <= 8'h00;
			status_two <= 8'h00;
		end else if (clk_en) begin
			status_one <= cur_s1;
			status_two <= cur_s2;
			if (!accept || state != ST_READ) begin
				out_cnt <= 3'h0;
				io_oe   <= 4'h0;
				io_out  <= 4'h0;
			end else begin
				// drive is released during hold; shift state is kept
				io_oe <= hold_now ? 4'h0 : (quad_instruction_mode ? 4'hF : 4'h2);
				if (fall) begin
					if (quad_instruction_mode) begin
						io_out  <= rd_data[7:4];
						out_sh  <= {rd_data[3:0], 4'h0};
						out_cnt <= out_cnt + 3'h4;
					end else begin
						io_out  <= {2'h0, rd_data[7], 1'b0};
						out_sh  <= {rd_data[6:0], 1'b0};
						out_cnt <= out_cnt + 3'h1;
					end
				end
			end
		end
	end

endmodule

// ### test/fsr_status_ctrl_assertions.sv
`timescale 1ns/1ps
module fsr_status_ctrl_chk (
	// clock and reset
	input wire       clk,
	input wire       reset_n,
	input wire       clk_en,
	// serial pins
	input wire       cs_n,
	input wire [3:0] io_in,
	input wire [3:0] io_oe,
	// memory control side
	input wire       array_busy,
	input wire       erase_suspended,
	input wire       program_suspended,
	input wire       array_abort,
	input wire       in_reset,
	// status view
	input wire [7:0] status_one,
	input wire [7:0] status_two,
	input wire       pin_function_select
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// reset-pin low time; saturates so a long hold never wraps under the limit
	reg [6:0] low_cnt;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			low_cnt <= 7'h00;
		else if (io_in[3] || !pin_function_select || status_two[1])
			low_cnt <= 7'h00;
		else if (clk_en && low_cnt != 7'h7F)
			low_cnt <= low_cnt + 7'h01;
	end
	property p_erase_susp;
		$rose(erase_suspended) |-> ##[1:3] status_two[7];
	endproperty
	a_erase_susp: assert property (p_erase_susp) else $error("erase suspend not shown");
	property p_prog_susp;
		$rose(program_suspended) |-> ##[1:3] status_two[2];
	endproperty
	a_prog_susp: assert property (p_prog_susp) else $error("program suspend not shown");
	property p_busy;
		$rose(array_busy) |-> ##[1:3] status_one[0];
	endproperty
	a_busy: assert property (p_busy) else $error("busy not shown");
	property p_wel_set;
		$rose(status_one[1]) |-> cs_n;
	endproperty
	a_wel_set: assert property (p_wel_set) else $error("write enable set inside a frame");
	property p_quiet;
		in_reset [*3] |-> !$rose(status_one[1]);
	endproperty
	a_quiet: assert property (p_quiet) else $error("command taken during reset");
	property p_abort_pulse;
		array_abort |=> !array_abort;
	endproperty
	a_abort_pulse: assert property (p_abort_pulse) else $error("abort longer than one cycle");
	property p_abort_reset;
		array_abort |-> ##[0:2] in_reset;
	endproperty
	a_abort_reset: assert property (p_abort_reset) else $error("abort without reset state");
	property p_reset_wel;
		array_abort |-> ##[1:4] !status_one[1];
	endproperty
	a_reset_wel: assert property (p_reset_wel) else $error("write enable kept over reset");
	property p_hold;
		(!cs_n && !io_in[3] && !pin_function_select && !status_two[1]) [*5] |-> io_oe == 4'h0;
	endproperty
	a_hold: assert property (p_hold) else $error("outputs driven during hold");
	property p_pin_reset;
		low_cnt == 7'h3C |-> in_reset;
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("reset pin ignored");
	c_abort: cover property (array_abort);
	c_busy: cover property ($rose(status_one[0]));
	c_pin: cover property (low_cnt == 7'h3C);
endmodule
bind fsr_status_ctrl fsr_status_ctrl_chk u_chk (
	.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .cs_n(cs_n), .io_in(io_in),
	.io_oe(io_oe), .array_busy(array_busy), .erase_suspended(erase_suspended),
	.program_suspended(program_suspended), .array_abort(array_abort),
	.in_reset(in_reset), .status_one(status_one), .status_two(status_two),
	.pin_function_select(pin_function_select)
);

// ### test/fsr_host.sv
`timescale 1ns/1ps
module fsr_host (
	// clock
	input  wire       clk,
	// serial pins
	output reg        cs_n,
	output reg        sclk,
	output wire [3:0] io_in,
	input  wire [3:0] io_out,
	input  wire [3:0] io_oe
);
	reg di;
	reg wp;
	reg hr;
	reg tgl;
	reg       qm;
	reg [3:0] qd;
	// an undriven data line toggles so a stale bit is never read as valid
	assign io_in = (io_oe & io_out) | (~io_oe & (qm ? qd : {hr, wp, tgl, di}));
	initial begin
		{cs_n, sclk, di, tgl} = 4'h8;
		{wp, hr} = 2'h3;
		{qm, qd} = 5'h00;
	end
	always @(posedge clk)
		tgl <= ~tgl;
	// mode 0 frame, msb first; rd_en appends one byte read back on io1
	task automatic xfer(input logic [7:0] q[$], input logic rd_en, output logic [7:0] rd);
		rd = 8'h00;
		@(posedge clk);
		#2 cs_n = 1'b0;
		foreach (q[i])
			for (int k = 7; k >= 0; k--) begin
				di = q[i][k];
				#80 sclk = 1'b1;
				#80 sclk = 1'b0;
			end
		if (rd_en)
			for (int k = 7; k >= 0; k--) begin
				#80 sclk = 1'b1;
				#70 rd[k] = io_in[1];
				#10 sclk = 1'b0;
			end
		#80 cs_n = 1'b1;
		di = ~di;
		#400;
	endtask
	// four-line frame, high nibble first; lines go back to pin roles at deselect
	task automatic qxfer(input logic [7:0] op, input logic rd_en, output logic [7:0] rd);
		rd = 8'h00;
		@(posedge clk);
		#2 cs_n = 1'b0;
		qm = 1'b1;
		for (int k = 1; k >= 0; k--) begin
			qd = op[4*k +: 4];
			#80 sclk = 1'b1;
			#80 sclk = 1'b0;
		end
		if (rd_en)
			for (int k = 1; k >= 0; k--) begin
				#80 sclk = 1'b1;
				#70 rd[4*k +: 4] = io_in;
				#10 sclk = 1'b0;
			end
		#80 cs_n = 1'b1;
		qm = 1'b0;
		#400;
	endtask
	task automatic sw_reset;
		logic [7:0] rd;
		xfer('{8'h66}, 1'b0, rd);
		xfer('{8'h99}, 1'b0, rd);
	endtask
endmodule

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam int REC = 1500; // recovery in clk cycles
	localparam int TW = 60;    // nv write of 50 clk plus margin
	reg        clk;
	reg        reset_n;
	reg        clk_en;
	reg        array_busy;
	reg        array_done;
	reg        erase_suspended;
	reg        program_suspended;
	reg        abort_seen;
	reg  [7:0] rd;
	int        mismatches;
	int        num_checks;
	int        cyc;
	wire       cs_n, sclk, array_abort, in_reset;
	wire       pin_function_select, quad_instruction_mode;
	wire [3:0] io_in, io_out, io_oe;
	wire [7:0] status_one, status_two;

	fsr_status_ctrl #(.T_W_US(1)) dut (
		.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .cs_n(cs_n), .sclk(sclk),
		.io_in(io_in), .io_out(io_out), .io_oe(io_oe), .array_busy(array_busy),
		.array_done(array_done), .erase_suspended(erase_suspended),
		.program_suspended(program_suspended), .array_abort(array_abort),
		.in_reset(in_reset), .status_one(status_one), .status_two(status_two),
		.pin_function_select(pin_function_select),
		.quad_instruction_mode(quad_instruction_mode)
	);
	fsr_host host (
		.clk(clk), .cs_n(cs_n), .sclk(sclk), .io_in(io_in), .io_out(io_out), .io_oe(io_oe)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// the whole run needs about 7300 cycles
	always @(posedge clk) begin
		if (array_abort)
			abort_seen <= 1'b1;
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic cmd(input logic [7:0] q[$]);
		host.xfer(q, 1'b0, rd);
		tick(8);
	endtask
	task automatic nv_write(input logic [7:0] q[$]);
		cmd('{8'h06});
		cmd(q);
		tick(TW);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic t_reset;
		chk(status_one, 8'h00);
		chk(status_two, 8'h00);
		chk({6'h00, pin_function_select, quad_instruction_mode}, 8'h00);
		{host.hr, host.cs_n} = 2'h0;
		tick(10);
		chk({4'h0, io_oe}, 8'h00);
		{host.hr, host.cs_n} = 2'h3;
		tick(5);
		// hold taken in the middle of a read must release the driven line
		fork
			host.xfer('{8'h05}, 1'b1, rd);
			begin
				#1600;
				chk({4'h0, io_oe}, 8'h02);
				host.hr = 1'b0;
				tick(6);
				chk({4'h0, io_oe}, 8'h00);
				host.hr = 1'b1;
			end
		join
		tick(4);
		$display("reset and hold test done");
	endtask
	task automatic t_wel;
		cmd('{8'h06});
		chk(status_one, 8'h02);
		host.xfer('{8'h05}, 1'b1, rd);
		chk(rd, 8'h02);
		tick(1);
		{clk_en, array_done} = 2'h1;
		tick(3);
		chk(status_one, 8'h02);
		clk_en = 1'b1;
		tick(1);
		array_done = 1'b0;
		{erase_suspended, program_suspended, array_busy} = 3'h7;
		tick(4);
		chk(status_one, 8'h01);
		chk(status_two, 8'h84);
		host.xfer('{8'h35}, 1'b1, rd);
		chk(rd, 8'h84);
		{erase_suspended, program_suspended, array_busy} = 3'h0;
		tick(4);
		chk(status_two, 8'h00);
		$display("write enable and status bits test done");
	endtask
	task automatic t_vol;
		cmd('{8'h50});
		cmd('{8'h01, 8'h7C, 8'h42});
		chk(status_one, 8'h7C);
		chk(status_two, 8'h42);
		host.sw_reset();
		chk({7'h00, in_reset}, 8'h01);
		cmd('{8'h06});
		chk(status_one, 8'h00);
		chk(status_two, 8'h00);
		tick(REC);
		$display("volatile write and software reset test done");
	endtask
	task automatic t_nv;
		host.wp = 1'b0;
		cmd('{8'h06});
		cmd('{8'h01, 8'h1C, 8'h00});
		chk({7'h00, status_one[0]}, 8'h01);
		tick(TW);
		chk(status_one, 8'h1C);
		cmd('{8'h01, 8'h00});
		chk(status_one, 8'h1C);
		cmd('{8'h06});
		cmd('{8'h66});
		host.xfer('{8'h05}, 1'b1, rd);
		chk(rd, 8'h1E);
		cmd('{8'h99});
		chk(status_one, 8'h1E);
		cmd('{8'h04});
		nv_write('{8'h01, 8'h9C});
		chk(status_one, 8'h9C);
		nv_write('{8'h01, 8'h1C});
		chk({status_one[7:2], 2'h0}, 8'h9C);
		host.wp = 1'b1;
		nv_write('{8'h01, 8'h1C});
		chk(status_one, 8'h1C);
		$display("non-volatile write and protect test done");
	endtask
	task automatic t_hw;
		nv_write('{8'h11, 8'h80});
		chk({7'h00, pin_function_select}, 8'h01);
		{abort_seen, array_busy, host.hr} = 3'h2;
		tick(60);
		chk({7'h00, in_reset}, 8'h01);
		cmd('{8'h06});
		{array_busy, host.hr} = 2'h1;
		tick(8);
		chk(status_one, 8'h1C);
		chk({6'h00, abort_seen, pin_function_select}, 8'h03);
		tick(REC);
		cmd('{8'h50});
		cmd('{8'h01, 8'h1C, 8'h02});
		chk(status_two, 8'h02);
		{abort_seen, host.hr} = 2'h0;
		tick(60);
		host.hr = 1'b1;
		tick(8);
		chk({6'h00, abort_seen, in_reset}, 8'h00);
		$display("hardware reset pin test done");
	endtask
	task automatic t_qpi;
		cmd('{8'h38});
		chk({7'h00, quad_instruction_mode}, 8'h01);
		host.qxfer(8'h05, 1'b1, rd);
		chk(rd, 8'h1C);
		host.qxfer(8'h66, 1'b0, rd);
		host.qxfer(8'h99, 1'b0, rd);
		chk({7'h00, quad_instruction_mode}, 8'h00);
		chk(status_two, 8'h00);
		$display("four-line mode and reset test done");
	endtask

	initial begin
		{reset_n, array_busy, array_done, erase_suspended, program_suspended} = 5'h00;
		{clk_en, abort_seen} = 2'h2;
		tick(3);
		reset_n = 1'b1;
		tick(5);
		t_reset();
		t_wel();
		t_vol();
		t_nv();
		t_hw();
		t_qpi();
		report_and_stop();
	end
endmodule
